// ---- rtl/mcc_pkg.sv ----
// Purpose: shared constants and types for the motor controller config bank
// Assumes: 200 MHz system clock, 16-bit registers on a 7-bit serial address
// Notes: all register contents reset to zero
package mcc_pkg;
    // clock
    localparam int unsigned CLK_HZ = 200_000_000;
    // register addresses
    localparam logic [6:0] ADDR_MAIN = 7'h00;
    localparam logic [6:0] ADDR_ADVANCE = 7'h01;
    localparam logic [6:0] ADDR_LOCK = 7'h02;
    localparam logic [6:0] ADDR_BASIC = 7'h03;
    localparam logic [15:0] REG_RESET = 16'h0000;
    // serial frame layout
    localparam int unsigned FRAME_BITS = 24;
    localparam int unsigned HDR_BITS = 8;
    localparam int unsigned RW_BIT = 23;
    localparam int unsigned ADDR_MSB = 22;
    localparam int unsigned ADDR_LSB = 16;
    // pwm rates and derived periods in clock cycles
    localparam int unsigned PWM_HZ_25K = 25_000;
    localparam int unsigned PWM_HZ_50K = 50_000;
    localparam int unsigned PWM_HZ_100K = 100_000;
    localparam int unsigned PWM_HZ_200K = 200_000;
    localparam logic [13:0] PWM_CYC_25K = 14'(CLK_HZ / PWM_HZ_25K);
    localparam logic [13:0] PWM_CYC_50K = 14'(CLK_HZ / PWM_HZ_50K);
    localparam logic [13:0] PWM_CYC_100K = 14'(CLK_HZ / PWM_HZ_100K);
    localparam logic [13:0] PWM_CYC_200K = 14'(CLK_HZ / PWM_HZ_200K);
    // field codes
    localparam logic [1:0] MODE_CLK_FREQ = 2'h0;
    localparam logic [1:0] MODE_CLK_PWM = 2'h1;
    localparam logic [1:0] MODE_REG_PWM = 2'h2;
    localparam logic [1:0] FB_HALL_U = 2'h0;
    localparam logic [1:0] FB_HALL_XOR = 2'h1;
    localparam logic [1:0] FB_AMP = 2'h2;
    localparam logic [1:0] FB_TACHOMETER_INPUT = 2'h3;
    // advance scaling and hall period width
    localparam int unsigned ADVANCE_DIV = 960;
    localparam int unsigned HALL_PERIOD_W = 24;

    typedef struct packed {
        logic [3:0] autogain_setpoint;
        logic enable_polarity;
        logic direction_polarity;
        logic brake_polarity;
        logic sync_rectify_enable;
        logic [1:0] pwm_frequency_select;
        logic [1:0] speed_control_mode;
        logic [1:0] feedback_source_select;
        logic disabled_brake_mode;
        logic retry_enable;
    } mcc_main_cfg_t;

    typedef struct packed {
        logic [7:0] lock_extra_revolutions;
        logic [7:0] minimum_speed_threshold;
    } mcc_lock_cfg_t;

    typedef struct packed {
        logic basic_mode;
        logic [2:0] speed_change_tolerance;
        logic [11:0] modulation_120;
    } mcc_basic_cfg_t;

    typedef struct packed {
        logic [6:0] addr;
        logic [15:0] data;
    } mcc_write_t;

    typedef enum logic [2:0] {
        LOCK_IDLE = 3'b001,
        LOCK_COUNT = 3'b010,
        LOCK_HELD = 3'b100
    } mcc_lock_state_t;
endpackage

// ---- rtl/mcc_serial_port.sv ----
// Purpose: serial slave port, 24-bit frames of rw, address and data
// Assumes: scs, sclk, sdati synchronous to clk; sclk high and low >= 2 clk
// Notes: write commits on scs fall after 24 or more bits, first 24 kept
module mcc_serial_port
    import mcc_pkg::*;
(
    // system
    input wire logic clk,
    input wire logic rst,
    // serial pins
    input wire logic scs,
    input wire logic sclk,
    input wire logic sdati,
    output logic sdato,
    output logic sdato_oe,
    // register side
    output logic [6:0] rd_addr,
    input wire logic [15:0] rdata,
    output logic wr_valid,
    output mcc_write_t wr
);
    logic scs_q;
    logic sclk_q;
    logic [4:0] bit_cnt;
    logic [23:0] shift;
    logic load_pending;
    logic [15:0] out_word;
    logic sclk_rise;
    logic sclk_fall;

    assign sclk_rise = scs && sclk && !sclk_q;
    assign sclk_fall = scs && !sclk && sclk_q;
    assign rd_addr = shift[6:0];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scs_q <= 1'b0;
            sclk_q <= 1'b0;
        end else begin
            scs_q <= scs;
            sclk_q <= sclk;
        end
    end

    // shift in on rising sclk, extra edges past the frame ignored
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bit_cnt <= 5'h00;
            shift <= 24'h00_0000;
        end else if (!scs) begin
            bit_cnt <= 5'h00;
        end else if (sclk_rise && bit_cnt < 5'(FRAME_BITS)) begin
            shift <= {shift[22:0], sdati};
            bit_cnt <= bit_cnt + 5'h01;
        end
    end

    // read: fetch word after header, present msb, then one bit per falling edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            load_pending <= 1'b0;
            out_word <= 16'h0000;
            sdato <= 1'b0;
            sdato_oe <= 1'b0;
        end else if (!scs) begin
            load_pending <= 1'b0;
            sdato_oe <= 1'b0;
            sdato <= 1'b0;
        end else begin
            load_pending <= sclk_rise && bit_cnt == 5'(HDR_BITS - 1) && shift[6];
            if (load_pending) begin
                out_word <= rdata;
                sdato <= rdata[15];
                sdato_oe <= 1'b1;
            end else if (sclk_fall && sdato_oe && bit_cnt > 5'(HDR_BITS)
                         && bit_cnt < 5'(FRAME_BITS)) begin
                sdato <= out_word[4'(5'd23 - bit_cnt)];
            end
        end
    end

    // write commit on chip select release
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_valid <= 1'b0;
            wr <= '0;
        end else begin
            wr_valid <= !scs && scs_q && bit_cnt == 5'(FRAME_BITS) && !shift[RW_BIT];
            wr.addr <= shift[ADDR_MSB:ADDR_LSB];
            wr.data <= shift[15:0];
        end
    end
endmodule

// ---- rtl/mcc_config_regs.sv ----
// Purpose: configuration register bank and its direct effects on the drive
// Assumes: all inputs synchronous to clk; serial port at registers main_control_config-basic_mode_config
// Notes: outputs registered; unmapped addresses read as zero
// Notes on behaviour
// - four-bit autogain setpoint in main bits 15:12
// - enable polarity bit selects active high/low enable
// - direction polarity bit inverts direction terminal
// - brake polarity bit selects brake high or low
// - bit 8 switches synchronous rectification
// - pwm select gives 25/50/100/200 kHz period
// - feedback source: hall u, hall xor, amp, tachometer_input
// - fault latches outputs off unless retry set
// - advance count is 1/960 hall period
// - lock after conditions plus extra hall periods
// - basic bit drops advance, forces 120 commutation
// - register mode takes speed from speed register
// - autogain setpoint only applies when autogain enabled
module mcc_config_regs
    import mcc_pkg::*;
#(
    parameter int unsigned PERIOD_W = HALL_PERIOD_W
)
(
    // system
    input wire logic clk,
    input wire logic rst,
    // serial pins
    input wire logic scs,
    input wire logic sclk,
    input wire logic sdati,
    output logic sdato,
    output logic sdato_oe,
    // control terminals
    input wire logic enable_in,
    input wire logic direction_in,
    input wire logic brake_in,
    // sensors
    input wire logic hall_u,
    input wire logic hall_v,
    input wire logic hall_w,
    input wire logic fg_amp_in,
    input wire logic tachometer_input,
    // loop status and commands
    input wire logic fault_in,
    input wire logic min_speed_met,
    input wire logic speed_tolerance_met,
    input wire logic autogain_enable,
    input wire logic [11:0] clock_speed_cmd,
    input wire logic [11:0] speed_register_cmd,
    // drive controls
    output logic device_active,
    output logic direction_eff,
    output logic brake_active,
    output logic sync_rectify_enable,
    output logic [13:0] pwm_period_cycles,
    output logic [1:0] speed_control_mode,
    output logic [11:0] speed_command,
    output logic speed_feedback_signal,
    output logic outputs_tristate,
    output logic low_side_on,
    output logic outputs_off,
    output logic [PERIOD_W-1:0] advance_cycles,
    output logic force_120_commutation,
    output logic speed_lock,
    output logic [3:0] autogain_setpoint_active,
    output logic [7:0] minimum_speed_threshold,
    output logic [2:0] speed_change_tolerance,
    output logic [11:0] modulation_120
);
    mcc_main_cfg_t cfg;
    logic [7:0] advance;
    mcc_lock_cfg_t lock_cfg;
    mcc_basic_cfg_t basic_cfg;
    logic [6:0] rd_addr;
    logic wr_valid;
    mcc_write_t wr;
    logic hall_u_q;
    logic hall_rise;
    logic [PERIOD_W-1:0] period_cnt;
    logic [PERIOD_W-1:0] hall_period;
    logic fault_latched;
    mcc_lock_state_t lock_state;
    mcc_lock_state_t next_lock_state;
    logic [7:0] lock_cnt;
    logic lock_cond;

    function automatic logic [15:0] read_word(input logic [6:0] a, input mcc_main_cfg_t m,
            input logic [7:0] adv, input mcc_lock_cfg_t l, input mcc_basic_cfg_t b);
        case (a)
            ADDR_MAIN: read_word = 16'(m);
            ADDR_ADVANCE: read_word = {8'h00, adv};
            ADDR_LOCK: read_word = 16'(l);
            ADDR_BASIC: read_word = 16'(b);
            default: read_word = 16'h0000;
        endcase
    endfunction

    function automatic logic [13:0] pwm_period(input logic [1:0] sel);
        case (sel)
            2'h0: pwm_period = PWM_CYC_25K;
            2'h1: pwm_period = PWM_CYC_50K;
            2'h2: pwm_period = PWM_CYC_100K;
            default: pwm_period = PWM_CYC_200K;
        endcase
    endfunction

    function automatic logic [PERIOD_W-1:0] scale_advance(input logic [PERIOD_W-1:0] per,
            input logic [7:0] adv);
        logic [PERIOD_W+7:0] prod;
        logic [PERIOD_W+7:0] quot;
        prod = {8'h00, per} * {{PERIOD_W{1'b0}}, adv};
        quot = prod / (PERIOD_W + 8)'(ADVANCE_DIV);
        scale_advance = quot[PERIOD_W-1:0];
    endfunction

    mcc_serial_port u_port (
        .clk(clk),
        .rst(rst),
        .scs(scs),
        .sclk(sclk),
        .sdati(sdati),
        .sdato(sdato),
        .sdato_oe(sdato_oe),
        .rd_addr(rd_addr),
        .rdata(read_word(rd_addr, cfg, advance, lock_cfg, basic_cfg)),
        .wr_valid(wr_valid),
        .wr(wr)
    );

    // register writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg <= mcc_main_cfg_t'(REG_RESET);
            advance <= 8'h00;
            lock_cfg <= mcc_lock_cfg_t'(REG_RESET);
            basic_cfg <= mcc_basic_cfg_t'(REG_RESET);
        end else if (wr_valid) begin
            if (wr.addr == ADDR_MAIN) begin
                cfg <= mcc_main_cfg_t'(wr.data);
            end
            if (wr.addr == ADDR_ADVANCE) begin
                advance <= wr.data[7:0];
            end
            if (wr.addr == ADDR_LOCK) begin
                lock_cfg <= mcc_lock_cfg_t'(wr.data);
            end
            if (wr.addr == ADDR_BASIC) begin
                basic_cfg <= mcc_basic_cfg_t'(wr.data);
            end
        end
    end

    // terminal polarity and static controls
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            device_active <= 1'b0;
            direction_eff <= 1'b0;
            brake_active <= 1'b0;
            sync_rectify_enable <= 1'b0;
            pwm_period_cycles <= PWM_CYC_25K;
            speed_control_mode <= MODE_CLK_FREQ;
            autogain_setpoint_active <= 4'h0;
            minimum_speed_threshold <= 8'h00;
            speed_change_tolerance <= 3'h0;
            modulation_120 <= 12'h000;
        end else begin
            device_active <= enable_in ^ cfg.enable_polarity;
            direction_eff <= direction_in ^ cfg.direction_polarity;
            brake_active <= brake_in ^ cfg.brake_polarity;
            sync_rectify_enable <= cfg.sync_rectify_enable;
            pwm_period_cycles <= pwm_period(cfg.pwm_frequency_select);
            speed_control_mode <= cfg.speed_control_mode;
            autogain_setpoint_active <= autogain_enable ? cfg.autogain_setpoint : 4'h0;
            minimum_speed_threshold <= lock_cfg.minimum_speed_threshold;
            speed_change_tolerance <= basic_cfg.speed_change_tolerance;
            modulation_120 <= basic_cfg.modulation_120;
        end
    end

    // speed command source and feedback select
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            speed_command <= 12'h000;
            speed_feedback_signal <= 1'b0;
        end else begin
            speed_command <= (cfg.speed_control_mode == MODE_REG_PWM) ?
                             speed_register_cmd : clock_speed_cmd;
            case (cfg.feedback_source_select)
                FB_HALL_U: speed_feedback_signal <= hall_u;
                FB_HALL_XOR: speed_feedback_signal <= hall_u ^ hall_v ^ hall_w;
                FB_AMP: speed_feedback_signal <= fg_amp_in;
                default: speed_feedback_signal <= tachometer_input;
            endcase
        end
    end

    // disabled output state and fault handling
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fault_latched <= 1'b0;
            outputs_tristate <= 1'b1;
            low_side_on <= 1'b0;
            outputs_off <= 1'b1;
        end else begin
            if (fault_in && !cfg.retry_enable) begin
                fault_latched <= 1'b1;
            end else if (!device_active) begin
                fault_latched <= 1'b0;
            end
            outputs_tristate <= !device_active && !cfg.disabled_brake_mode;
            low_side_on <= !device_active && cfg.disabled_brake_mode;
            outputs_off <= !device_active || fault_latched || fault_in;
        end
    end

    // hall u period measurement and advance scaling
    assign hall_rise = hall_u && !hall_u_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hall_u_q <= 1'b0;
            period_cnt <= '0;
            hall_period <= '0;
            advance_cycles <= '0;
            force_120_commutation <= 1'b0;
        end else begin
            hall_u_q <= hall_u;
            if (hall_rise) begin
                hall_period <= period_cnt;
                period_cnt <= PERIOD_W'(1);
            end else if (period_cnt != '1) begin
                period_cnt <= period_cnt + PERIOD_W'(1);
            end
            advance_cycles <= basic_cfg.basic_mode ? '0 :
                              scale_advance(hall_period, advance);
            force_120_commutation <= basic_cfg.basic_mode;
        end
    end

    // speed lock qualification
    assign lock_cond = min_speed_met && speed_tolerance_met;
    always_comb begin
        next_lock_state = lock_state;
        case (lock_state)
            LOCK_IDLE: if (lock_cond) next_lock_state = LOCK_COUNT;
            LOCK_COUNT: begin
                if (!lock_cond) begin
                    next_lock_state = LOCK_IDLE;
                end else if (lock_cnt >= lock_cfg.lock_extra_revolutions) begin
                    next_lock_state = LOCK_HELD;
                end
            end
            LOCK_HELD: if (!lock_cond) next_lock_state = LOCK_IDLE;
            default: next_lock_state = LOCK_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lock_state <= LOCK_IDLE;
            lock_cnt <= 8'h00;
            speed_lock <= 1'b0;
        end else begin
            lock_state <= next_lock_state;
            speed_lock <= next_lock_state == LOCK_HELD;
            if (lock_state != LOCK_COUNT) begin
                lock_cnt <= 8'h00;
            end else if (hall_rise && lock_cnt != 8'hff) begin
                lock_cnt <= lock_cnt + 8'h01;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence fault_no_retry;
        fault_in && !cfg.retry_enable;
    endsequence
    sequence stays_enabled;
        device_active [*2];
    endsequence

    enable_pol_a: assert property (cfg.enable_polarity && !enable_in |=> device_active)
        else $error("enable low not active with inverted polarity");
    dir_pol_a: assert property (cfg.direction_polarity |=> direction_eff == !$past(direction_in))
        else $error("direction not inverted");
    brake_pol_a: assert property (!cfg.brake_polarity && brake_in |=> brake_active)
        else $error("brake high not applied");
    pwm_rate_a: assert property (cfg.pwm_frequency_select == 2'h3 |=> pwm_period_cycles == 14'd1000)
        else $error("200 kHz period wrong");
    feedback_xor_a: assert property (cfg.feedback_source_select == FB_HALL_XOR |=>
        speed_feedback_signal == $past(hall_u ^ hall_v ^ hall_w))
        else $error("hall xor feedback wrong");
    disabled_brake_a: assert property (!device_active && cfg.disabled_brake_mode |=>
        low_side_on && !outputs_tristate)
        else $error("disabled brake output wrong");
    fault_latch_a: assert property (fault_no_retry ##1 stays_enabled |-> outputs_off)
        else $error("fault did not latch outputs off");
    lock_cause_a: assert property ($rose(speed_lock) |-> $past(lock_cond))
        else $error("lock set without conditions");
    basic_force_a: assert property (basic_cfg.basic_mode |=> advance_cycles == '0 &&
        force_120_commutation)
        else $error("basic mode not forcing 120");
    reg_speed_a: assert property (cfg.speed_control_mode == MODE_REG_PWM |=>
        speed_command == $past(speed_register_cmd))
        else $error("register speed command not used");
    autogain_gate_a: assert property (!autogain_enable |=> autogain_setpoint_active == 4'h0)
        else $error("setpoint active without autogain");
endmodule

// ---- sim/tb_top.sv ----
// Purpose: self-checking bench for the motor controller config bank
// Assumes: serial frames of rw, address and data, sclk phases of 3 clk
// Notes: random stimulus from a fixed seed plus hand-picked corner cases
module tb_top
    import mcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic scs = 1'b0, sclk = 1'b0, sdati = 1'b0;
    logic enable_in = 1'b0, direction_in = 1'b0, brake_in = 1'b0;
    logic hall_u = 1'b0, hall_v = 1'b0, hall_w = 1'b0, fg_amp_in = 1'b0, tachometer_input = 1'b0;
    logic fault_in = 1'b0, min_speed_met = 1'b0, speed_tolerance_met = 1'b0;
    logic autogain_enable = 1'b0;
    logic [11:0] clock_speed_cmd = 12'h000, speed_register_cmd = 12'h000;
    logic sdato, sdato_oe, device_active, direction_eff, brake_active, sync_rectify_enable;
    logic [13:0] pwm_period_cycles;
    logic [1:0] speed_control_mode;
    logic [11:0] speed_command, modulation_120;
    logic speed_feedback_signal, outputs_tristate, low_side_on, outputs_off;
    logic [23:0] advance_cycles;
    logic force_120_commutation, speed_lock;
    logic [3:0] autogain_setpoint_active;
    logic [7:0] minimum_speed_threshold;
    logic [2:0] speed_change_tolerance;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;
    int seed = 46640;
    logic [15:0] v, r;
    logic oe_seen = 1'b0;

    always #2.5 clk = ~clk;

    mcc_config_regs #(.PERIOD_W(24)) DUT (.clk(clk), .rst(rst), .scs(scs), .sclk(sclk),
        .sdati(sdati), .sdato(sdato), .sdato_oe(sdato_oe), .enable_in(enable_in),
        .direction_in(direction_in), .brake_in(brake_in), .hall_u(hall_u), .hall_v(hall_v),
        .hall_w(hall_w), .fg_amp_in(fg_amp_in), .tachometer_input(tachometer_input),
        .fault_in(fault_in), .min_speed_met(min_speed_met),
        .speed_tolerance_met(speed_tolerance_met), .autogain_enable(autogain_enable),
        .clock_speed_cmd(clock_speed_cmd), .speed_register_cmd(speed_register_cmd),
        .device_active(device_active), .direction_eff(direction_eff),
        .brake_active(brake_active), .sync_rectify_enable(sync_rectify_enable),
        .pwm_period_cycles(pwm_period_cycles), .speed_control_mode(speed_control_mode),
        .speed_command(speed_command), .speed_feedback_signal(speed_feedback_signal),
        .outputs_tristate(outputs_tristate), .low_side_on(low_side_on),
        .outputs_off(outputs_off), .advance_cycles(advance_cycles),
        .force_120_commutation(force_120_commutation), .speed_lock(speed_lock),
        .autogain_setpoint_active(autogain_setpoint_active),
        .minimum_speed_threshold(minimum_speed_threshold),
        .speed_change_tolerance(speed_change_tolerance), .modulation_120(modulation_120));

    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures = failures + 1;
            $display("[FAIL] %0t timeout", $time);
            end_of_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one 24-bit frame, msb first; read bits sampled before rises 9..24
    task automatic frame(input logic [23:0] f, output logic [15:0] rd);
        rd = 16'h0000;
        @(posedge clk);
        scs <= 1'b1;
        wait_clk(2);
        for (int i = 23; i >= 0; i--) begin
            sdati <= f[i];
            sclk <= 1'b0;
            wait_clk(3);
            if (i < 16) begin
                rd[i] = sdato;
            end
            if (i == 0) begin
                oe_seen = sdato_oe;
            end
            sclk <= 1'b1;
            wait_clk(3);
        end
        sclk <= 1'b0;
        wait_clk(2);
        scs <= 1'b0;
        wait_clk(5);
    endtask

    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        logic [15:0] dummy;
        frame({1'b0, a, d}, dummy);
    endtask

    task automatic rdreg(input logic [6:0] a, output logic [15:0] d);
        frame({1'b1, a, 16'h0000}, d);
    endtask

    function automatic logic fb_exp(input logic [1:0] sel);
        case (sel)
            2'h0: return hall_u;
            2'h1: return hall_u ^ hall_v ^ hall_w;
            2'h2: return fg_amp_in;
            default: return tachometer_input;
        endcase
    endfunction

    task automatic hall_rises(input int n, input int half);
        repeat (n) begin
            hall_u <= 1'b1;
            wait_clk(half);
            hall_u <= 1'b0;
            wait_clk(half);
        end
    endtask

    initial begin
        wait_clk(6);
        rst <= 1'b0;
        wait_clk(2);
        // reset values and pwm default
        for (int a = 0; a < 4; a++) begin
            rdreg(7'(a), r);
            chk(r, REG_RESET, "reset value");
        end
        chk(pwm_period_cycles, 14'd8000, "pwm reset");
        chk(oe_seen, 1'b1, "sdato driven in read");
        chk(sdato_oe, 1'b0, "sdato released");
        $display("test reset done");
        // main register: every code of the pwm, mode and feedback fields, random rest
        for (int i = 0; i < 8; i++) begin
            v = 16'($random(seed));
            v[7:6] = 2'(i);
            v[5:4] = 2'(i + 1);
            v[3:2] = 2'(i + 2);
            wr(ADDR_MAIN, v);
            @(posedge clk);
            {enable_in, direction_in, brake_in, hall_u, hall_v, hall_w} <= 6'($random(seed));
            {fg_amp_in, tachometer_input, autogain_enable} <= 3'($random(seed));
            clock_speed_cmd <= 12'($random(seed));
            speed_register_cmd <= 12'($random(seed));
            rdreg(ADDR_MAIN, r);
            chk(r, v, "main readback");
            chk(device_active, enable_in ^ v[11], "enable");
            chk(direction_eff, direction_in ^ v[10], "direction");
            chk(brake_active, brake_in ^ v[9], "brake");
            chk(sync_rectify_enable, v[8], "sync rect");
            chk(pwm_period_cycles, 14'd8000 >> v[7:6], "pwm period");
            chk(speed_control_mode, v[5:4], "mode");
            chk(speed_command, (v[5:4] == MODE_REG_PWM) ? speed_register_cmd
                : clock_speed_cmd, "speed cmd");
            chk(speed_feedback_signal, fb_exp(v[3:2]), "feedback");
            chk(outputs_tristate, !(enable_in ^ v[11]) && !v[1], "coast");
            chk(low_side_on, !(enable_in ^ v[11]) && v[1], "low side");
            chk(autogain_setpoint_active, autogain_enable ? v[15:12] : 4'h0, "autogain");
        end
        $display("test main register done");
        // reserved bits of advance register and unmapped address
        wr(ADDR_ADVANCE, 16'hFFFF);
        chk(oe_seen, 1'b0, "no drive in write");
        rdreg(ADDR_ADVANCE, r);
        chk(r, 16'h00FF, "reserved bits");
        wr(7'h05, 16'hA5A5);
        rdreg(7'h05, r);
        chk(r, 16'h0000, "unmapped");
        $display("test reserved done");
        // advance scaling from a 40-cycle hall period
        wr(ADDR_ADVANCE, 16'h00F0);
        wr(ADDR_BASIC, 16'h0000);
        hall_rises(4, 20);
        wait_clk(3);
        chk(advance_cycles, 24'd10, "advance");
        v = 16'h8000 | 16'($random(seed));
        wr(ADDR_BASIC, v);
        chk(force_120_commutation, 1'b1, "basic forces 120");
        chk(advance_cycles, 24'd0, "basic drops advance");
        chk(speed_change_tolerance, v[14:12], "tolerance copy");
        chk(modulation_120, v[11:0], "mod120 copy");
        wr(ADDR_BASIC, 16'h0123);
        chk(force_120_commutation, 1'b0, "basic clear");
        chk(modulation_120, 12'h123, "mod120 second copy");
        $display("test advance done");
        // fault latch then automatic retry
        wr(ADDR_MAIN, 16'h0000);
        enable_in <= 1'b1;
        wait_clk(3);
        chk(outputs_off, 1'b0, "running");
        fault_in <= 1'b1;
        wait_clk(1);
        fault_in <= 1'b0;
        wait_clk(4);
        chk(outputs_off, 1'b1, "latched off");
        enable_in <= 1'b0;
        wait_clk(3);
        enable_in <= 1'b1;
        wr(ADDR_MAIN, 16'h0001);
        fault_in <= 1'b1;
        wait_clk(1);
        fault_in <= 1'b0;
        wait_clk(4);
        chk(outputs_off, 1'b0, "retry");
        $display("test fault done");
        // speed lock waits for extra hall periods
        wr(ADDR_LOCK, 16'h0347);
        rdreg(ADDR_LOCK, r);
        chk(r, 16'h0347, "lock readback");
        chk(minimum_speed_threshold, 8'h47, "min speed copy");
        min_speed_met <= 1'b1;
        wait_clk(4);
        chk(speed_lock, 1'b0, "one condition");
        speed_tolerance_met <= 1'b1;
        wait_clk(2);
        hall_rises(2, 4);
        chk(speed_lock, 1'b0, "too few periods");
        hall_rises(3, 4);
        chk(speed_lock, 1'b1, "locked");
        speed_tolerance_met <= 1'b0;
        wait_clk(3);
        chk(speed_lock, 1'b0, "lock drops");
        $display("test speed lock done");
        // inverted enable: low terminal means active
        wr(ADDR_MAIN, 16'h0800);
        enable_in <= 1'b0;
        wait_clk(3);
        chk(device_active, 1'b1, "enable active low");
        $display("test enable polarity done");
        end_of_test();
    end
endmodule
